// ### rtl/mfm_pkg.sv
/*
  constants, field layouts and carrier types for the module management
  flag monitor. assumes a 10 MHz system clock.
*/
package mfm_pkg;

  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint T_INIT_MS = 64'd2000;
  localparam longint T_RST_MIN_US = 64'd2;
  localparam int INIT_CYC = int'(T_INIT_MS * CLK_HZ / 64'd1000);
  // least time, so round up
  localparam int RST_MIN_CYC =
    int'((T_RST_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  // 7-bit form of target address a0h
  localparam logic [6:0] DEV_ADDR = 7'h50;

  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_LOS = 8'h03;
  localparam logic [7:0] OFS_FAULT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h05;
  localparam logic [7:0] OFS_PAGE = 8'h7f;
  localparam int STAT_NOTRDY_BIT = 0;

  localparam int LOW_PAGE_BYTES = 128;
  localparam int PAGE_BITS = 2;
  localparam int RAM_AW = 9;
  localparam int RAM_WORDS = 512;

  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  localparam int SYNC_W = 12;
  // scl, sda and reset pin idle high
  localparam logic [11:0] SYNC_RST = 12'h007;

  typedef struct packed {
    logic [3:0] fault;
    logic [3:0] los;
  } mfm_flags_t;

  typedef struct packed {
    logic [3:0] txFault;
    logic [3:0] rxLos;
    logic lpReq;
    logic rstPin;
    logic sda;
    logic scl;
  } mfm_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK = 5'h04,
    ST_SEND = 5'h08,
    ST_HACK = 5'h10
  } mfm_state_t;

endpackage

// ### rtl/mfm_sync2.sv
/*
  two flip-flop synchroniser for every pin that enters from outside.
  assumes the pins are quasi-static against sys_clk.
*/
`timescale 1ns/1ps
module mfm_sync2 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] din,
  output logic [11:0] dout
);

  logic [11:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= mfm_pkg::SYNC_RST;
      dout <= mfm_pkg::SYNC_RST;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule

// ### rtl/mfm_page_ram.sv
/*
  upper page storage: one write port, one registered read port.
  assumes the caller forms {page, offset} addresses.
*/
`timescale 1ns/1ps
module mfm_page_ram (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [8:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [8:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] mem [mfm_pkg::RAM_WORDS];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// ### rtl/mfm_mgmt_top.sv
/*
  management side of a pluggable transceiver: two-wire target, paged
  memory, start-up readiness, latched flags and the interrupt pin.
  assumes scl is slow against sys_clk (several clocks per phase) and
  that sda is open drain, resolved outside from sdaOe.
*/
// How it works
// - fixed 128-byte lower page always visible
// - upper pages chosen by page select byte
// - answer only target address a0h
// - ready within 2000 ms of start
// - reset pin low over 2 us resets
// - ready within 2000 ms after pin release
// - bus answers only once ready
// - clear not-ready bit and raise interrupt
// - low power within 100 us of request
// - interrupt low within 200 ms of cause
// - flags clear on read, interrupt releases
// - loss of signal sets flag and interrupt
// - any condition sets flag and interrupt; a flag whose mask_reg bit is set does not pull the interrupt
// - ready means not-ready bit cleared, interrupt
// - clear applied when read transaction ends
`timescale 1ns/1ps
module mfm_mgmt_top #(
  parameter int unsigned INIT_CYC = mfm_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic reset_in_n,
  input wire logic low_power_request,
  input wire logic [3:0] rxLos,
  input wire logic [3:0] txFault,
  output logic irq_out_n,
  output logic lowPowerActive,
  output logic moduleReady
);

  mfm_pkg::mfm_pins_t pins;
  logic [11:0] pinsSync;
  logic sclPrev_reg, sdaPrev_reg;
  logic [3:0] losPrev_reg, faultPrev_reg;
  logic [7:0] pinLowCnt_reg;
  logic pinRst_reg;
  logic [31:0] initCnt_reg;
  logic ready_reg, initFlag_reg;
  mfm_pkg::mfm_flags_t flags_reg;
  logic [7:0] mask_reg, page_reg;
  logic clrLosPend_reg, clrFaultPend_reg, clrStatPend_reg;
  mfm_pkg::mfm_state_t state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] sh_reg, tx_reg, ptr_reg;
  logic [1:0] phase_reg;
  logic rdMode_reg, nack_reg, sdaOe_reg, irq_reg, lp_reg;
  logic [7:0] ramRd, rdByte, statusByte;
  logic sclRise, sclFall, startCond, stopCond, endTrans;
  logic byteDone, wrStrobe, loadStrobe, addrMatch, softRst, initDone;
  logic clrLos, clrFault, clrStat;
  logic [3:0] losEv, faultEv;

  // maps a lower-page offset to its byte; unused bytes read zero
  function automatic logic [7:0] lowRead(input logic [6:0] a,
      input logic [7:0] st, input logic [7:0] fl, input logic [7:0] mk,
      input logic [7:0] pg);
    logic [7:0] r;
    r = 8'h00;
    if ({1'b0, a} == mfm_pkg::OFS_STATUS) r = st;
    if ({1'b0, a} == mfm_pkg::OFS_LOS) r = {4'h0, fl[3:0]};
    if ({1'b0, a} == mfm_pkg::OFS_FAULT) r = {4'h0, fl[7:4]};
    if ({1'b0, a} == mfm_pkg::OFS_MASK) r = mk;
    if ({1'b0, a} == mfm_pkg::OFS_PAGE) r = pg;
    return r;
  endfunction

  mfm_sync2 uSync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din({txFault, rxLos, low_power_request, reset_in_n, sdaIn, sclIn}),
    .dout(pinsSync)
  );
  assign pins = pinsSync;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      losPrev_reg <= 4'h0;
      faultPrev_reg <= 4'h0;
    end else begin
      sclPrev_reg <= pins.scl;
      sdaPrev_reg <= pins.sda;
      losPrev_reg <= pins.rxLos;
      faultPrev_reg <= pins.txFault;
    end
  end

  assign sclRise = pins.scl & ~sclPrev_reg;
  assign sclFall = ~pins.scl & sclPrev_reg;
  assign startCond = sclPrev_reg & pins.scl & sdaPrev_reg & ~pins.sda;
  assign stopCond = sclPrev_reg & pins.scl & ~sdaPrev_reg & pins.sda;
  // a nacked read leaves the engine idle before its stop, so no state gate
  assign endTrans = startCond | stopCond;
  assign losEv = pins.rxLos & ~losPrev_reg;
  assign faultEv = pins.txFault & ~faultPrev_reg;

  // short glitches on the reset pin are ignored
  always_ff @(posedge sys_clk) begin
    if (!rst_n || pins.rstPin) begin
      pinLowCnt_reg <= 8'h00;
      pinRst_reg <= 1'b0;
    end else if (pinLowCnt_reg == 8'(mfm_pkg::RST_MIN_CYC)) begin
      pinRst_reg <= 1'b1;
    end else begin
      pinLowCnt_reg <= pinLowCnt_reg + 8'h01;
    end
  end
  assign softRst = pinRst_reg;

  assign initDone = !ready_reg && (initCnt_reg == 32'(INIT_CYC - 1));

  // restarts on power-up and on the pin's release
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softRst) begin
      initCnt_reg <= 32'h0;
      ready_reg <= 1'b0;
    end else if (initDone) begin
      ready_reg <= 1'b1;
    end else if (!ready_reg) begin
      initCnt_reg <= initCnt_reg + 32'h1;
    end
  end
  assign statusByte = {7'h00, ~ready_reg};
  assign moduleReady = ready_reg;

  assign clrLos = endTrans & clrLosPend_reg;
  assign clrFault = endTrans & clrFaultPend_reg;
  assign clrStat = endTrans & clrStatPend_reg;

  // events win over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softRst) begin
      flags_reg <= '0;
      initFlag_reg <= 1'b0;
    end else begin
      flags_reg.los <= flags_reg.los & ~{4{clrLos}} | losEv;
      flags_reg.fault <= flags_reg.fault & ~{4{clrFault}} | faultEv;
      initFlag_reg <= (initFlag_reg & ~clrStat) | initDone;
    end
  end

  // clear is armed by the read, applied when the transaction ends
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softRst || endTrans) begin
      clrLosPend_reg <= 1'b0;
      clrFaultPend_reg <= 1'b0;
      clrStatPend_reg <= 1'b0;
    end else if (loadStrobe) begin
      if (ptr_reg == mfm_pkg::OFS_LOS) clrLosPend_reg <= 1'b1;
      if (ptr_reg == mfm_pkg::OFS_FAULT) clrFaultPend_reg <= 1'b1;
      if (ptr_reg == mfm_pkg::OFS_STATUS) clrStatPend_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b1;
    end else begin
      irq_reg <= ~(|(flags_reg & ~mask_reg) | initFlag_reg);
    end
  end
  assign irq_out_n = irq_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lp_reg <= 1'b0;
    end else begin
      lp_reg <= pins.lpReq;
    end
  end
  assign lowPowerActive = lp_reg;

  assign addrMatch = (sh_reg[7:1] == mfm_pkg::DEV_ADDR)
    && ready_reg;
  assign byteDone = (state_reg == mfm_pkg::ST_RECV) && sclFall &&
    (bitCnt_reg == 4'h8) && !startCond && !stopCond;
  assign wrStrobe = byteDone && (phase_reg == 2'd2);
  assign loadStrobe = sclFall && !startCond && !stopCond &&
    (((state_reg == mfm_pkg::ST_ACK) && rdMode_reg) ||
     ((state_reg == mfm_pkg::ST_HACK) && !nack_reg));

  // lower page is always there; offsets 80h up go to the selected page
  assign rdByte = ptr_reg[7] ? ramRd :
    lowRead(ptr_reg[6:0], statusByte, flags_reg, mask_reg, page_reg);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || softRst) begin
      mask_reg <= mfm_pkg::MASK_RST;
      page_reg <= mfm_pkg::PAGE_RST;
    end else if (wrStrobe) begin
      if (ptr_reg == mfm_pkg::OFS_MASK) mask_reg <= sh_reg;
      if (ptr_reg == mfm_pkg::OFS_PAGE) page_reg <= sh_reg;
    end
  end

  mfm_page_ram uRam (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wrEn(wrStrobe && ptr_reg[7]),
    .wrAddr({page_reg[mfm_pkg::PAGE_BITS-1:0], ptr_reg[6:0]}),
    .wrData(sh_reg),
    .rdAddr({page_reg[mfm_pkg::PAGE_BITS-1:0], ptr_reg[6:0]}),
    .rdData(ramRd)
  );

  // target engine; sda changes only while scl is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softRst || stopCond) begin
      state_reg <= mfm_pkg::ST_IDLE;
      sdaOe_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      phase_reg <= 2'd0;
    end else if (startCond) begin
      state_reg <= mfm_pkg::ST_RECV;
      sdaOe_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      phase_reg <= 2'd0;
    end else if (loadStrobe) begin
      state_reg <= mfm_pkg::ST_SEND;
      tx_reg <= rdByte;
      sdaOe_reg <= ~rdByte[7];
      bitCnt_reg <= 4'h1;
      ptr_reg <= ptr_reg + 8'h01;
    end else begin
      case (state_reg)
        mfm_pkg::ST_RECV: begin
          if (sclRise) begin
            sh_reg <= {sh_reg[6:0], pins.sda};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            if (phase_reg == 2'd0 && !addrMatch) begin
              state_reg <= mfm_pkg::ST_IDLE;
            end else begin
              state_reg <= mfm_pkg::ST_ACK;
              sdaOe_reg <= 1'b1;
              if (phase_reg == 2'd0) rdMode_reg <= sh_reg[0];
              if (phase_reg == 2'd1) ptr_reg <= sh_reg;
              if (phase_reg == 2'd2) ptr_reg <= ptr_reg + 8'h01;
            end
          end
        end
        mfm_pkg::ST_ACK: begin
          if (sclFall) begin
            state_reg <= mfm_pkg::ST_RECV;
            sdaOe_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            phase_reg <= (phase_reg == 2'd0) ? 2'd1 : 2'd2;
          end
        end
        mfm_pkg::ST_SEND: begin
          if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              state_reg <= mfm_pkg::ST_HACK;
              sdaOe_reg <= 1'b0;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sdaOe_reg <= ~tx_reg[6];
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        mfm_pkg::ST_HACK: begin
          if (sclRise) begin
            nack_reg <= pins.sda;
          end else if (sclFall) begin
            state_reg <= mfm_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= mfm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign sdaOe = sdaOe_reg;
  assign sdaOut = 1'b0; // open drain, only ever pulls low

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_los_irq:
    assert property (((losEv & ~mask_reg[3:0]) != 4'h0) && !softRst
      |-> ##2 !irq_out_n) else $error("los event did not pull irq low");
  a_fault_flag:
    assert property ((faultEv != 4'h0) && !softRst
      |=> (flags_reg.fault & $past(faultEv)) == $past(faultEv))
      else $error("fault event not latched");
  a_flag_latch:
    assert property (!softRst && !clrLos
      |=> (flags_reg.los & $past(flags_reg.los)) == $past(flags_reg.los))
      else $error("los flag dropped without a read");
  a_irq_hold:
    assert property ((|(flags_reg & ~mask_reg)) |=> !irq_out_n)
      else $error("irq released while unmasked flag set");
  a_irq_release:
    assert property (clrLos ##1 ((flags_reg & ~mask_reg) == 8'h00
      && !initFlag_reg) |=> irq_out_n)
      else $error("irq not released after clear on read");
  a_init_irq:
    assert property ($rose(ready_reg) |-> !statusByte[0] ##1 !irq_out_n)
      else $error("ready without not-ready clear and irq");
  a_init_bound:
    assert property (!ready_reg |-> initCnt_reg < INIT_CYC)
      else $error("init count ran past its limit");
  a_bus_ready:
    assert property ((state_reg == mfm_pkg::ST_ACK) && (phase_reg == 2'd0)
      |-> ready_reg) else $error("address acked before ready");
  a_pin_reset:
    assert property ((pinLowCnt_reg == 8'(mfm_pkg::RST_MIN_CYC))
      && !pins.rstPin |-> ##2 !ready_reg)
      else $error("long reset pulse did not reset");
  a_lp_fast:
    assert property ($rose(pins.lpReq) |=> lowPowerActive)
      else $error("low power request not followed");

  c_ready: cover property ($rose(ready_reg));
  c_clear_read: cover property (clrLos ##2 irq_out_n);
  c_pin_reset: cover property (softRst ##1 !softRst);
  c_read_byte: cover property (loadStrobe && ptr_reg[7]);

endmodule

// ### sim/mfm_host_model.sv
/*
  two-wire bus host model: start, stop, register write and read.
  assumes the bench resolves sda as a pulled-up open drain wire.
*/
`timescale 1ns/1ps
module mfm_host_model #(
  // scl period is 2 * HALF + 2 clocks: 800 ns at 10 MHz
  parameter int HALF = 3
) (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // also a repeated start; scl stands high between frames
  task automatic start();
    sdaLow = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sdaLow = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sdaLow = 1'b0;
    tick(HALF);
  endtask
  // hold after scl falls, so sda never moves with it
  task automatic bitx(input logic b, output logic r);
    sdaLow = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sdaWire;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] v, input logic ak,
      output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], q[i]);
    end
    bitx(ak, nak);
  endtask
  task automatic wrReg(input logic [6:0] dev, input logic [7:0] ofs,
      input logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({dev, 1'b0}, 1'b1, q, n0);
    xfer(ofs, 1'b1, q, n1);
    xfer(v, 1'b1, q, n2);
    stop();
    ok = ~(n0 | n1 | n2);
  endtask
  // single byte read, closed by a host nack
  task automatic rdReg(input logic [6:0] dev, input logic [7:0] ofs,
      output logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({dev, 1'b0}, 1'b1, q, n0);
    xfer(ofs, 1'b1, q, n1);
    start();
    xfer({dev, 1'b1}, 1'b1, q, n2);
    xfer(8'hff, 1'b1, v, n3);
    stop();
    ok = ~(n0 | n1 | n2);
  endtask
endmodule

// ### sim/mfm_mgmt_top_tb_top.sv
/*
  self-checking bench for the management block, with a bus host model.
  assumes the start-up count is cut to 2000 cycles for a short run.
*/
`timescale 1ns/1ps
module mfm_mgmt_top_tb_top;
  localparam int INIT = 2000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic resetPinN = 1'b1;
  logic lpReq = 1'b0;
  logic [3:0] rxLos = 4'h0;
  logic [3:0] txFault = 4'h0;
  logic scl, sdaLow, sdaOut, sdaOe, sdaWire, irqN, lpAct, ready, ok;
  logic [2:0] obs;
  logic [7:0] d;
  int errorCnt = 0;
  int nChecks = 0;
  int cyc = 0;
  int relCyc = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  assign sdaWire = ~((sdaOe & ~sdaOut) | sdaLow);
  assign obs = {lpAct, ready, irqN};
  mfm_mgmt_top #(.INIT_CYC(INIT)) mfm_mgmt_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .reset_in_n(resetPinN),
    .low_power_request(lpReq), .rxLos(rxLos), .txFault(txFault),
    .irq_out_n(irqN), .lowPowerActive(lpAct), .moduleReady(ready));
  mfm_host_model hostInst (
    .sys_clk(sys_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
  task finishTest();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // w: 0 interrupt pin, 1 ready, 2 low power
  task waitSig(input int w, input logic lvl, input int lim);
    int n;
    n = 0;
    while (obs[w] !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        chk({7'h0, obs[w]}, {7'h0, lvl});
        finishTest();
      end
    end
  endtask
  task rd(input logic [7:0] ofs);
    hostInst.rdReg(mfm_pkg::DEV_ADDR, ofs, d, ok);
  endtask
  task wr(input logic [7:0] ofs, input logic [7:0] v);
    hostInst.wrReg(mfm_pkg::DEV_ADDR, ofs, v, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task testInit();
    chk({7'h0, irqN}, 8'h01);
    rd(mfm_pkg::OFS_STATUS);
    chk({7'h0, ok}, 8'h00);
    waitSig(1, 1'b1, INIT + 10 - (cyc - relCyc));
    waitSig(0, 1'b0, 5);
    rd(mfm_pkg::OFS_STATUS);
    chk({7'h0, ok}, 8'h01);
    chk({7'h0, d[mfm_pkg::STAT_NOTRDY_BIT]}, 8'h00);
    waitSig(0, 1'b1, 50);
    $display("test init done");
  endtask
  task testFlags();
    rxLos = 4'h4;
    waitSig(0, 1'b0, 50);
    rxLos = 4'h0;
    repeat (20) @(negedge sys_clk);
    chk({7'h0, irqN}, 8'h00);
    rd(mfm_pkg::OFS_LOS);
    chk(d & 8'h0f, 8'h04);
    waitSig(0, 1'b1, 50);
    rd(mfm_pkg::OFS_LOS);
    chk(d & 8'h0f, 8'h00);
    rxLos = 4'h2;
    txFault = 4'h8;
    waitSig(0, 1'b0, 50);
    rd(mfm_pkg::OFS_LOS);
    chk(d & 8'h0f, 8'h02);
    repeat (20) @(negedge sys_clk);
    chk({7'h0, irqN}, 8'h00);
    rd(mfm_pkg::OFS_FAULT);
    chk(d & 8'h0f, 8'h08);
    waitSig(0, 1'b1, 50);
    rxLos = 4'h0;
    txFault = 4'h0;
    $display("test flags done");
  endtask
  task testMask();
    wr(mfm_pkg::OFS_MASK, 8'h01);
    rxLos = 4'h1;
    repeat (20) @(negedge sys_clk);
    chk({7'h0, irqN}, 8'h01);
    rd(mfm_pkg::OFS_LOS);
    chk(d & 8'h0f, 8'h01);
    rxLos = 4'h0;
    $display("test mask done");
  endtask
  task testPage();
    wr(mfm_pkg::OFS_PAGE, 8'h01);
    wr(8'h80, 8'ha5);
    wr(mfm_pkg::OFS_PAGE, 8'h02);
    wr(8'h80, 8'h5a);
    rd(mfm_pkg::OFS_MASK);
    chk(d, 8'h01);
    wr(mfm_pkg::OFS_PAGE, 8'h01);
    rd(8'h80);
    chk(d, 8'ha5);
    hostInst.rdReg(mfm_pkg::DEV_ADDR ^ 7'h01, 8'h00, d, ok);
    chk({7'h0, ok}, 8'h00);
    $display("test page done");
  endtask
  task testLowPower();
    lpReq = 1'b1;
    waitSig(2, 1'b1, 1000);
    lpReq = 1'b0;
    waitSig(2, 1'b0, 1000);
    $display("test low power done");
  endtask
  task testPinReset();
    resetPinN = 1'b0;
    repeat (10) @(negedge sys_clk);
    resetPinN = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk({7'h0, ready}, 8'h01);
    // held 4 us, past the 2 us minimum
    resetPinN = 1'b0;
    repeat (40) @(negedge sys_clk);
    chk({7'h0, ready}, 8'h00);
    resetPinN = 1'b1;
    waitSig(1, 1'b1, INIT + 10);
    waitSig(0, 1'b0, 5);
    rd(mfm_pkg::OFS_STATUS);
    chk({7'h0, d[mfm_pkg::STAT_NOTRDY_BIT]}, 8'h00);
    waitSig(0, 1'b1, 50);
    rd(mfm_pkg::OFS_MASK);
    chk(d, mfm_pkg::MASK_RST);
    $display("test pin reset done");
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    relCyc = cyc;
    testInit();
    testFlags();
    testMask();
    testPage();
    testLowPower();
    testPinReset();
    finishTest();
  end
endmodule
